// ==== engine_speed_governor_control_regs.svh ====
// Register offsets, reset values and timing constants of the speed governor
// How it works
// RQ1 - Target speed is accelerator command plus idle raise and cold-start advance offsets.
// RQ2 - Final target speed saturates at the low idle and high idle limits.
// RQ3 - Speed error feeds a PID loop that yields the target rack position.
// RQ4 - Rack error feeds a second PID loop that yields the target actuator current.
// RQ5 - During start or acceleration the target rack rises at a limited rate.
// RQ6 - EGR opening is 0 to 54 steps, chosen from engine speed and load factor.
// RQ7 - EGR valve stays closed while coolant is below 60 C.
// RQ8 - At cold start, energise advance solenoid when coolant is at or below 5/10 C.
// RQ9 - Solenoid drops when coolant passes the threshold or after five minutes.
// RQ10 - After a stop, no re-energise until coolant falls 5 C below stop temperature.
// RQ11 - While the solenoid is on, add 50 or 75 per minute by variant.
// RQ12 - The raised target never exceeds the high idle speed.
// RQ13 - When actuation ends the offset is removed with no outside command.
// RQ14 - Load factor percent from idle, maximum, minimum and actual rack positions.
// RQ15 - Load factor is reported as PWM or as a value for CAN.
// RQ16 - Droop when the droop select contact is open, isochronous when closed.
// RQ17 - A configuration bit inverts the droop select input.
// RQ18 - Optionally, under droop the target is held at or above low idle.
// RQ19 - Low idle limit rises with falling coolant when idle raise is enabled.
// RQ20 - High idle limit falls with falling coolant when smoke suppression is enabled.
// RQ21 - Target speed is low-pass filtered to limit overshoot and undershoot.
// RQ22 - Three speed-select contacts change the target speed.
// RQ23 - At engine stop the EGR valve is driven fully closed.
// RQ24 - Each control tick updates offsets, clamp, speed loop, then rack loop.
// RQ25 - After reset: solenoid off, timer clear, zero EGR until coolant is valid.
`ifndef ENGINE_SPEED_GOVERNOR_CONTROL_REGS_SVH
`define ENGINE_SPEED_GOVERNOR_CONTROL_REGS_SVH

`define REG_CTRL          8'h00
`define REG_LOW_IDLE      8'h04
`define REG_HIGH_IDLE     8'h08
`define REG_SEL_A         8'h0c
`define REG_SEL_B         8'h10
`define REG_SEL_C         8'h14
`define REG_SPEED_GAIN    8'h18
`define REG_RACK_GAIN     8'h1c
`define REG_RACK_IDLE     8'h20
`define REG_RACK_MAX      8'h24
`define REG_RACK_MIN      8'h28
`define REG_TEMP_CFG      8'h2c
`define REG_FILT_TRANS    8'h30
`define REG_EGR_SPEED     8'h34
`define REG_STATUS        8'h38
`define REG_OUTPUTS       8'h3c

`define CTRL_IDLE_RAISE   0
`define CTRL_SMOKE        1
`define CTRL_DROOP_INV    2
`define CTRL_DROOP_HOLD   3
`define CTRL_VARIANT_HOT  4
`define CTRL_LOAD_CAN     5

`define RST_CTRL          7'h00
`define RST_LOW_IDLE      16'h0320
`define RST_HIGH_IDLE     16'h09c4
`define RST_SPEED_GAIN    24'h041010
`define RST_RACK_GAIN     24'h020820
`define RST_RACK_IDLE     16'h0800
`define RST_RACK_MAX      16'h3000
`define RST_RACK_MIN      16'h0400
`define RST_TEMP_CFG      32'h04022828
`define RST_FILT_TRANS    32'h00200003
`define RST_EGR_SPEED     32'h0a8c04b0

`define CLOCK_MHZ         250
`define CONTROL_TICK_US   1000
`define CSD_MAX_TIME_S    300
`define CSD_COLD_LOW_C    5
`define CSD_COLD_HIGH_C   10
`define CSD_REARM_DROP_C  5
`define CSD_OFFSET_LOW    50
`define CSD_OFFSET_HIGH   75
`define EGR_MIN_TEMP_C    60
`define EGR_MAX_STEPS     54
`define DROOP_KNEE_PCT    30
`define LOAD_FULL_PCT     100

`endif

// ==== engine_speed_governor_control_pkg.sv ====
// Types shared by the speed governor
package engine_speed_governor_control_pkg;

	typedef enum logic [2:0] {PH_WAIT, PH_OFFSET, PH_CLAMP, PH_SPEED, PH_RACK} phase_t;

	typedef struct packed {
		logic signed [31:0] integ;
		logic signed [16:0] prev_err;
	} pid_t;

	typedef struct packed {
		pid_t        st;
		logic [15:0] out;
	} pid_res_t;

	typedef struct packed {
		logic [6:0]         ctrl;
		logic [15:0]        low_idle;
		logic [15:0]        high_idle;
		logic signed [15:0] sel_a;
		logic signed [15:0] sel_b;
		logic signed [15:0] sel_c;
		logic [23:0]        speed_gain;
		logic [23:0]        rack_gain;
		logic [15:0]        rack_idle;
		logic [15:0]        rack_max;
		logic [15:0]        rack_min;
		logic [31:0]        temp_cfg;
		logic [31:0]        filt_trans;
		logic [31:0]        egr_speed;
	} cfg_t;

	typedef struct packed {
		cfg_t               cfg;
		phase_t             phase;
		logic [31:0]        tick_cnt;
		logic signed [17:0] target_raw;
		logic [23:0]        filt_acc;
		logic [15:0]        target_speed;
		pid_t               speed_pid;
		pid_t               rack_pid;
		logic [15:0]        target_rack;
		logic [15:0]        current;
		logic [5:0]         egr;
		logic               solenoid;
		logic               inhibit;
		logic signed [7:0]  stop_temp;
		logic [31:0]        csd_timer;
		logic [6:0]         load;
		logic               droop;
		logic [6:0]         pwm_cnt;
		logic               pwm;
		logic [6:0]         load_can;
		logic               waitreq;
		logic [31:0]        readdata;
	} state_t;

endpackage : engine_speed_governor_control_pkg

// ==== engine_speed_governor_control.sv ====
// Speed governor: target speed chain, cascaded PID loops, EGR, cold-start advance, load factor
//
// Register access over Avalon-MM and the register addresses were left to the implementer.
`include "engine_speed_governor_control_regs.svh"

module engine_speed_governor_control #(
	parameter int TICK_CYCLES = `CONTROL_TICK_US * `CLOCK_MHZ
) (
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire logic [7:0]        address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	input  wire logic [3:0]        byteenable,
	output logic [31:0]            readdata,
	output logic                   waitrequest,
	input  wire logic [15:0]       accel_command,
	input  wire logic [15:0]       measured_speed,
	input  wire logic [15:0]       measured_rack,
	input  wire logic signed [7:0] coolant_temp,
	input  wire logic              coolant_valid,
	input  wire logic              engine_starting,
	input  wire logic              engine_accelerating,
	input  wire logic              engine_stop,
	input  wire logic              droop_select_input,
	input  wire logic              speed_select_input_a,
	input  wire logic              speed_select_input_b,
	input  wire logic              speed_select_input_c,
	output logic [15:0]            target_speed,
	output logic [15:0]            target_rack,
	output logic [15:0]            actuator_current,
	output logic [5:0]             egr_steps,
	output logic                   cold_start_timing_advance,
	output logic                   load_factor_pwm,
	output logic [6:0]             load_factor_can,
	output logic                   droop_active
);

	localparam int CSD_MAX_TICKS = (`CSD_MAX_TIME_S * 1000000) / `CONTROL_TICK_US;

	generate
		if (TICK_CYCLES < 8) begin : g_tick_check
			$error("TICK_CYCLES too small for the control sequence");
		end
	endgenerate

	engine_speed_governor_control_pkg::state_t s_q;
	engine_speed_governor_control_pkg::state_t s_d;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
	                                            input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge_bytes

	// Integrator is clamped so a long saturation does not wind up past recovery
	function automatic engine_speed_governor_control_pkg::pid_res_t pid_step(
		input engine_speed_governor_control_pkg::pid_t st,
		input logic signed [16:0] err,
		input logic [23:0] gain,
		input logic [15:0] limit);
		logic signed [31:0] integ;
		logic signed [17:0] deriv;
		logic signed [47:0] acc;
		engine_speed_governor_control_pkg::pid_res_t r;
		integ = st.integ + 32'(err);
		if (integ > 32'sh00ffffff) begin
			integ = 32'sh00ffffff;
		end else if (integ < -32'sh00ffffff) begin
			integ = -32'sh00ffffff;
		end
		deriv = 18'(err) - 18'(st.prev_err);
		acc = $signed({1'b0, gain[7:0]}) * err
		    + $signed({1'b0, gain[15:8]}) * (integ >>> 8)
		    + $signed({1'b0, gain[23:16]}) * deriv;
		acc = acc >>> 4;
		if (acc < 48'sh0) begin
			r.out = 16'h0;
		end else if (acc > $signed({32'h0, limit})) begin
			r.out = limit;
		end else begin
			r.out = acc[15:0];
		end
		r.st.integ = integ;
		r.st.prev_err = err;
		return r;
	endfunction : pid_step

	function automatic logic [31:0] read_reg(input engine_speed_governor_control_pkg::state_t s,
	                                         input logic [7:0] a);
		if (a == `REG_CTRL) begin
			return {25'h0, s.cfg.ctrl};
		end else if (a == `REG_LOW_IDLE) begin
			return {16'h0, s.cfg.low_idle};
		end else if (a == `REG_HIGH_IDLE) begin
			return {16'h0, s.cfg.high_idle};
		end else if (a == `REG_SEL_A) begin
			return {16'h0, s.cfg.sel_a};
		end else if (a == `REG_SEL_B) begin
			return {16'h0, s.cfg.sel_b};
		end else if (a == `REG_SEL_C) begin
			return {16'h0, s.cfg.sel_c};
		end else if (a == `REG_SPEED_GAIN) begin
			return {8'h0, s.cfg.speed_gain};
		end else if (a == `REG_RACK_GAIN) begin
			return {8'h0, s.cfg.rack_gain};
		end else if (a == `REG_RACK_IDLE) begin
			return {16'h0, s.cfg.rack_idle};
		end else if (a == `REG_RACK_MAX) begin
			return {16'h0, s.cfg.rack_max};
		end else if (a == `REG_RACK_MIN) begin
			return {16'h0, s.cfg.rack_min};
		end else if (a == `REG_TEMP_CFG) begin
			return s.cfg.temp_cfg;
		end else if (a == `REG_FILT_TRANS) begin
			return s.cfg.filt_trans;
		end else if (a == `REG_EGR_SPEED) begin
			return s.cfg.egr_speed;
		end else if (a == `REG_STATUS) begin
			return {5'h0, s.inhibit, s.droop, s.solenoid, 1'b0, s.load, s.target_speed};
		end else if (a == `REG_OUTPUTS) begin
			return {10'h0, s.egr, s.target_rack};
		end else begin
			return 32'h0;
		end
	endfunction : read_reg

	logic signed [8:0]  cool;
	logic [15:0]        idle_raise;
	logic [15:0]        smoke_cut;
	logic [15:0]        low_eff;
	logic [15:0]        high_eff;
	logic signed [17:0] csd_offset;
	logic signed [17:0] sel_offset;

	// Coolant dependent limits, recomputed every cycle from live inputs
	always_comb begin
		cool = 9'(coolant_temp);
		idle_raise = 16'h0;
		smoke_cut = 16'h0;
		if (s_q.cfg.ctrl[`CTRL_IDLE_RAISE] && coolant_valid && cool < $signed({1'b0, s_q.cfg.temp_cfg[7:0]})) begin
			idle_raise = 16'(($signed({1'b0, s_q.cfg.temp_cfg[7:0]}) - cool) * $signed({1'b0, s_q.cfg.temp_cfg[23:16]})); // [RQ19]
		end
		if (s_q.cfg.ctrl[`CTRL_SMOKE] && coolant_valid && cool < $signed({1'b0, s_q.cfg.temp_cfg[15:8]})) begin
			smoke_cut = 16'(($signed({1'b0, s_q.cfg.temp_cfg[15:8]}) - cool) * $signed({1'b0, s_q.cfg.temp_cfg[23:16]})); // [RQ20]
		end
		low_eff = s_q.cfg.low_idle + idle_raise;
		high_eff = (s_q.cfg.high_idle > low_eff + smoke_cut) ? s_q.cfg.high_idle - smoke_cut : low_eff;
		csd_offset = 18'sh0;
		if (s_q.solenoid) begin
			csd_offset = s_q.cfg.ctrl[`CTRL_VARIANT_HOT] ? 18'(`CSD_OFFSET_HIGH) : 18'(`CSD_OFFSET_LOW); // [RQ11] [RQ13]
		end
		sel_offset = (speed_select_input_a ? 18'(s_q.cfg.sel_a) : 18'sh0)
		           + (speed_select_input_b ? 18'(s_q.cfg.sel_b) : 18'sh0)
		           + (speed_select_input_c ? 18'(s_q.cfg.sel_c) : 18'sh0); // [RQ22]
	end

	always_comb begin
		engine_speed_governor_control_pkg::pid_res_t pr;
		logic signed [17:0] t;
		logic signed [24:0] filt_in;
		logic signed [24:0] filt_step;
		logic signed [16:0] err;
		logic signed [16:0] num;
		logic [15:0]        den;
		logic [23:0]        pct;
		logic [15:0]        rate;
		logic [7:0]         egr_calc;
		logic signed [8:0]  thr;
		logic               bus_req;
		pr = '0;
		t = 18'sh0;
		filt_in = 25'sh0;
		filt_step = 25'sh0;
		err = 17'sh0;
		num = 17'sh0;
		den = 16'h0;
		pct = 24'h0;
		rate = s_q.cfg.filt_trans[31:16];
		egr_calc = 8'h0;
		thr = s_q.cfg.ctrl[`CTRL_VARIANT_HOT] ? 9'(`CSD_COLD_HIGH_C) : 9'(`CSD_COLD_LOW_C);
		bus_req = read | write;
		s_d = s_q;

		// Avalon slave: one wait cycle, then the access completes
		s_d.waitreq = 1'b1;
		if (bus_req && s_q.waitreq) begin
			s_d.waitreq = 1'b0;
			s_d.readdata = read ? read_reg(s_q, address) : 32'h0;
		end
		if (write && !s_q.waitreq) begin
			if (address == `REG_CTRL) begin
				s_d.cfg.ctrl = 7'(merge_bytes({25'h0, s_q.cfg.ctrl}, writedata, byteenable));
			end else if (address == `REG_LOW_IDLE) begin
				s_d.cfg.low_idle = 16'(merge_bytes({16'h0, s_q.cfg.low_idle}, writedata, byteenable));
			end else if (address == `REG_HIGH_IDLE) begin
				s_d.cfg.high_idle = 16'(merge_bytes({16'h0, s_q.cfg.high_idle}, writedata, byteenable));
			end else if (address == `REG_SEL_A) begin
				s_d.cfg.sel_a = 16'(merge_bytes({16'h0, s_q.cfg.sel_a}, writedata, byteenable));
			end else if (address == `REG_SEL_B) begin
				s_d.cfg.sel_b = 16'(merge_bytes({16'h0, s_q.cfg.sel_b}, writedata, byteenable));
			end else if (address == `REG_SEL_C) begin
				s_d.cfg.sel_c = 16'(merge_bytes({16'h0, s_q.cfg.sel_c}, writedata, byteenable));
			end else if (address == `REG_SPEED_GAIN) begin
				s_d.cfg.speed_gain = 24'(merge_bytes({8'h0, s_q.cfg.speed_gain}, writedata, byteenable));
			end else if (address == `REG_RACK_GAIN) begin
				s_d.cfg.rack_gain = 24'(merge_bytes({8'h0, s_q.cfg.rack_gain}, writedata, byteenable));
			end else if (address == `REG_RACK_IDLE) begin
				s_d.cfg.rack_idle = 16'(merge_bytes({16'h0, s_q.cfg.rack_idle}, writedata, byteenable));
			end else if (address == `REG_RACK_MAX) begin
				s_d.cfg.rack_max = 16'(merge_bytes({16'h0, s_q.cfg.rack_max}, writedata, byteenable));
			end else if (address == `REG_RACK_MIN) begin
				s_d.cfg.rack_min = 16'(merge_bytes({16'h0, s_q.cfg.rack_min}, writedata, byteenable));
			end else if (address == `REG_TEMP_CFG) begin
				s_d.cfg.temp_cfg = merge_bytes(s_q.cfg.temp_cfg, writedata, byteenable);
			end else if (address == `REG_FILT_TRANS) begin
				s_d.cfg.filt_trans = merge_bytes(s_q.cfg.filt_trans, writedata, byteenable);
			end else if (address == `REG_EGR_SPEED) begin
				s_d.cfg.egr_speed = merge_bytes(s_q.cfg.egr_speed, writedata, byteenable);
			end
		end

		s_d.droop = ~(droop_select_input ^ s_q.cfg.ctrl[`CTRL_DROOP_INV]); // [RQ16] [RQ17]

		// Load factor reporting: PWM period of 100 clocks, or a plain value for CAN
		s_d.pwm_cnt = (s_q.pwm_cnt >= 7'(`LOAD_FULL_PCT - 1)) ? 7'h0 : s_q.pwm_cnt + 7'h1;
		s_d.pwm = !s_q.cfg.ctrl[`CTRL_LOAD_CAN] && (s_q.pwm_cnt < s_q.load); // [RQ15]
		s_d.load_can = s_q.cfg.ctrl[`CTRL_LOAD_CAN] ? s_q.load : 7'h0; // [RQ15]

		case (s_q.phase)
			engine_speed_governor_control_pkg::PH_WAIT: begin
				if (s_q.tick_cnt >= 32'(TICK_CYCLES - 1)) begin
					s_d.tick_cnt = 32'h0;
					s_d.phase = engine_speed_governor_control_pkg::PH_OFFSET; // [RQ24]
				end else begin
					s_d.tick_cnt = s_q.tick_cnt + 32'h1;
				end
			end
			engine_speed_governor_control_pkg::PH_OFFSET: begin
				s_d.tick_cnt = s_q.tick_cnt + 32'h1;
				s_d.target_raw = $signed({2'b00, accel_command}) + $signed({2'b00, idle_raise})
				               + csd_offset + sel_offset; // [RQ1]
				s_d.phase = engine_speed_governor_control_pkg::PH_CLAMP;
			end
			engine_speed_governor_control_pkg::PH_CLAMP: begin
				s_d.tick_cnt = s_q.tick_cnt + 32'h1;
				t = s_q.target_raw;
				if (t > $signed({2'b00, high_eff})) begin
					t = $signed({2'b00, high_eff}); // [RQ2] [RQ12]
				end else if (t < $signed({2'b00, low_eff})) begin
					t = $signed({2'b00, low_eff}); // [RQ2]
				end
				// Virtual droop lowers the target above the load knee
				if (s_q.droop && s_q.load > 7'(`DROOP_KNEE_PCT)) begin
					t = t - 18'((s_q.load - 7'(`DROOP_KNEE_PCT)) * s_q.cfg.temp_cfg[31:24]);
					if (s_q.cfg.ctrl[`CTRL_DROOP_HOLD] && t < $signed({2'b00, low_eff})) begin
						t = $signed({2'b00, low_eff}); // [RQ18]
					end
				end
				if (t < 18'sh0) begin
					t = 18'sh0;
				end
				// First order filter stays between its old and new value, so limits still hold
				filt_in = $signed({t[16:0], 8'h0});
				filt_step = (filt_in - $signed({1'b0, s_q.filt_acc})) >>> s_q.cfg.filt_trans[3:0];
				s_d.filt_acc = 24'($signed({1'b0, s_q.filt_acc}) + filt_step); // [RQ21]
				s_d.target_speed = s_d.filt_acc[23:8];
				s_d.phase = engine_speed_governor_control_pkg::PH_SPEED;
			end
			engine_speed_governor_control_pkg::PH_SPEED: begin
				s_d.tick_cnt = s_q.tick_cnt + 32'h1;
				err = $signed({1'b0, s_q.target_speed}) - $signed({1'b0, measured_speed});
				pr = pid_step(s_q.speed_pid, err, s_q.cfg.speed_gain, s_q.cfg.rack_max); // [RQ3]
				s_d.speed_pid = pr.st;
				if ((engine_starting || engine_accelerating) && pr.out > s_q.target_rack
				    && pr.out - s_q.target_rack > rate) begin
					s_d.target_rack = s_q.target_rack + rate; // [RQ5]
				end else begin
					s_d.target_rack = pr.out;
				end
				s_d.phase = engine_speed_governor_control_pkg::PH_RACK;
			end
			engine_speed_governor_control_pkg::PH_RACK: begin
				s_d.tick_cnt = s_q.tick_cnt + 32'h1;
				err = $signed({1'b0, s_q.target_rack}) - $signed({1'b0, measured_rack});
				pr = pid_step(s_q.rack_pid, err, s_q.cfg.rack_gain, 16'hffff); // [RQ4]
				s_d.rack_pid = pr.st;
				s_d.current = pr.out;

				// Load percent above idle rack, both referenced to minimum rack
				num = $signed({1'b0, measured_rack - s_q.cfg.rack_min})
				    - $signed({1'b0, s_q.cfg.rack_idle - s_q.cfg.rack_min});
				den = s_q.cfg.rack_max - s_q.cfg.rack_idle;
				if (num > 17'sh0 && s_q.cfg.rack_max > s_q.cfg.rack_idle) begin
					pct = (24'(num[15:0]) * 24'(`LOAD_FULL_PCT)) / 24'(den); // [RQ14]
				end
				s_d.load = (pct > 24'(`LOAD_FULL_PCT)) ? 7'(`LOAD_FULL_PCT) : pct[6:0];

				// Cold-start advance solenoid
				if (!coolant_valid) begin
					s_d.solenoid = 1'b0; // [RQ25]
				end else if (s_q.solenoid) begin
					s_d.csd_timer = s_q.csd_timer + 32'h1;
					if (cool > thr || s_q.csd_timer >= 32'(CSD_MAX_TICKS - 1)) begin
						s_d.solenoid = 1'b0; // [RQ9]
						s_d.inhibit = 1'b1;
						s_d.stop_temp = coolant_temp;
					end
				end else if (s_q.inhibit) begin
					if (cool <= 9'(s_q.stop_temp) - $signed(9'(`CSD_REARM_DROP_C))) begin
						s_d.inhibit = 1'b0; // [RQ10]
					end
				end else if (engine_starting && cool <= thr) begin
					s_d.solenoid = 1'b1; // [RQ8]
					s_d.csd_timer = 32'h0;
				end

				// EGR opening scales with load inside the enabled speed window
				egr_calc = 8'((16'(s_d.load) * 16'd35) >> 6);
				if (egr_calc > 8'(`EGR_MAX_STEPS)) begin
					egr_calc = 8'(`EGR_MAX_STEPS); // [RQ6]
				end
				if (engine_stop) begin
					s_d.egr = 6'h0; // [RQ23]
				end else if (!coolant_valid || cool < $signed(9'(`EGR_MIN_TEMP_C))) begin
					s_d.egr = 6'h0; // [RQ7] [RQ25]
				end else if (measured_speed < s_q.cfg.egr_speed[15:0] || measured_speed > s_q.cfg.egr_speed[31:16]) begin
					s_d.egr = 6'h0;
				end else begin
					s_d.egr = egr_calc[5:0]; // [RQ6]
				end
				s_d.phase = engine_speed_governor_control_pkg::PH_WAIT;
			end
			default: begin
				s_d.phase = engine_speed_governor_control_pkg::PH_WAIT;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s_q <= '0;
			s_q.cfg.ctrl <= `RST_CTRL;
			s_q.cfg.low_idle <= `RST_LOW_IDLE;
			s_q.cfg.high_idle <= `RST_HIGH_IDLE;
			s_q.cfg.speed_gain <= `RST_SPEED_GAIN;
			s_q.cfg.rack_gain <= `RST_RACK_GAIN;
			s_q.cfg.rack_idle <= `RST_RACK_IDLE;
			s_q.cfg.rack_max <= `RST_RACK_MAX;
			s_q.cfg.rack_min <= `RST_RACK_MIN;
			s_q.cfg.temp_cfg <= `RST_TEMP_CFG;
			s_q.cfg.filt_trans <= `RST_FILT_TRANS;
			s_q.cfg.egr_speed <= `RST_EGR_SPEED;
			s_q.phase <= engine_speed_governor_control_pkg::PH_WAIT;
			s_q.waitreq <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign readdata = s_q.readdata;
	assign waitrequest = s_q.waitreq;
	assign target_speed = s_q.target_speed;
	assign target_rack = s_q.target_rack;
	assign actuator_current = s_q.current;
	assign egr_steps = s_q.egr;
	assign cold_start_timing_advance = s_q.solenoid;
	assign load_factor_pwm = s_q.pwm;
	assign load_factor_can = s_q.load_can;
	assign droop_active = s_q.droop;

endmodule : engine_speed_governor_control

// ==== engine_speed_governor_control_asserts.sv ====
// Concurrent checks on the speed governor ports
module governor_checker #(
	parameter int TICK_CYCLES = 250000
) (
	input wire logic              clock,
	input wire logic              reset,
	input wire logic signed [7:0] coolant_temp,
	input wire logic              coolant_valid,
	input wire logic              engine_starting,
	input wire logic              engine_stop,
	input wire logic [15:0]       target_speed,
	input wire logic [5:0]        egr_steps,
	input wire logic              cold_start_timing_advance,
	input wire logic              load_factor_pwm,
	input wire logic [6:0]        load_factor_can
);
	// Stop may land anywhere in a tick, so allow one full period plus phases
	localparam int STOP_WAIT = TICK_CYCLES + 8;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	AST_EGR_RANGE: assert property (egr_steps <= 6'h36) else $error("egr above range");
	AST_EGR_COLD: assert property ($changed(egr_steps) && egr_steps != 6'h00 |-> coolant_temp >= 8'sh3c)
		else $error("egr opened when cold");
	AST_EGR_STOP: assert property (egr_steps != 6'h00 && $changed(egr_steps) |-> !engine_stop)
		else $error("egr opened at stop");
	AST_RESET_OUT: assert property ($fell(reset) |-> !cold_start_timing_advance && egr_steps == 6'h00)
		else $error("outputs not clear after reset");
	AST_SOL_ON: assert property ($rose(cold_start_timing_advance) |-> engine_starting && coolant_temp <= 8'sh0a)
		else $error("solenoid on without cold start");
	logic [31:0] warm_on_q;
	always_ff @(posedge clock) begin
		warm_on_q <= (reset || !(cold_start_timing_advance && coolant_temp > 8'sh0a && coolant_valid))
			? 32'h0 : warm_on_q + 32'h1;
	end
	AST_SOL_OFF: assert property (warm_on_q <= 32'(STOP_WAIT)) else $error("solenoid not dropped");
	AST_HIGH_IDLE: assert property (target_speed <= 16'h09c4) else $error("target above high idle");
	AST_CAN_PWM: assert property (load_factor_can != 7'h00 |-> !load_factor_pwm)
		else $error("pwm active with can report");
	AST_LOAD_CAP: assert property (load_factor_can <= 7'h64) else $error("load above full");
endmodule : governor_checker
bind engine_speed_governor_control governor_checker #(.TICK_CYCLES(TICK_CYCLES)) governor_checker_inst (
	.clock, .reset, .coolant_temp, .coolant_valid, .engine_starting, .engine_stop, .target_speed,
	.egr_steps, .cold_start_timing_advance, .load_factor_pwm, .load_factor_can);

// ==== governor_plant.sv ====
// Sensor stand-in presenting rack and speed readings
module governor_plant (
	input  wire logic        clock,
	input  wire logic [15:0] rack_set,
	input  wire logic [15:0] speed_set,
	output logic      [15:0] measured_rack,
	output logic      [15:0] measured_speed
);
	timeunit 1ns;
	timeprecision 1ps;
	// Registered like a sampled sensor, so readings never change mid-edge
	always_ff @(posedge clock) begin
		measured_rack  <= rack_set;
		measured_speed <= speed_set;
	end
endmodule : governor_plant

// ==== engine_speed_governor_control_bench.sv ====
// Register and control-tick tests of the speed governor
`include "engine_speed_governor_control_regs.svh"
module engine_speed_governor_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, reset = 1, read = 0, write = 0, waitrequest, starting = 0, stop = 0, valid = 0;
	logic droop_in = 1, sol, pwm, droop, sa = 0, sb = 0, sc = 0;
	logic [7:0] address = 8'h00;
	logic [31:0] writedata = 32'h0, readdata, rd;
	logic [15:0] accel = 16'h03e8, rack_set = 16'h2000, mrack, mspeed, tspeed, track, cur;
	logic signed [7:0] cool = 8'sh46;
	logic [5:0] egr;
	logic [6:0] lcan;
	int n_mismatch = 0, check_count = 0, cycles = 0, pwm_high = 0;
	always #2 clock = ~clock;
	governor_plant governor_plant_inst (.clock(clock), .rack_set(rack_set), .speed_set(16'h07d0),
		.measured_rack(mrack), .measured_speed(mspeed));
	engine_speed_governor_control #(.TICK_CYCLES(16)) engine_speed_governor_control_inst (
		.clock(clock), .reset(reset), .address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest), .accel_command(accel),
		.measured_speed(mspeed), .measured_rack(mrack), .coolant_temp(cool), .coolant_valid(valid),
		.engine_starting(starting), .engine_accelerating(1'b0), .engine_stop(stop),
		.droop_select_input(droop_in), .speed_select_input_a(sa), .speed_select_input_b(sb),
		.speed_select_input_c(sc), .target_speed(tspeed), .target_rack(track), .actuator_current(cur),
		.egr_steps(egr), .cold_start_timing_advance(sol), .load_factor_pwm(pwm),
		.load_factor_can(lcan), .droop_active(droop));
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop
	task check(input string name, input logic [31:0] exp, input logic [31:0] seen);
		check_count++;
		if (seen !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, seen);
			n_mismatch++;
		end
	endtask : check
	// Request held until waitrequest is sampled low, per Avalon
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		do @(posedge clock); while (waitrequest !== 1'b0);
		rd = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask : bus
	// Tick period is TICK_CYCLES, the four phase cycles included; 60 clocks cover three ticks and the lag
	task ticks;
		repeat (60) @(posedge clock);
	endtask : ticks
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	initial begin
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		bus(0, `REG_CTRL, 0);
		check("ctrl", 32'h0, rd);
		bus(0, `REG_LOW_IDLE, 0);
		check("low_idle", 32'h320, rd);
		bus(0, 8'h40, 0);
		check("unmapped", 32'h0, rd);
		bus(1, `REG_FILT_TRANS, 32'h00200000);
		ticks();
		check("egr invalid", 0, egr);
		valid <= 1'b1;
		ticks();
		check("egr", 32, egr);
		bus(0, `REG_STATUS, 0);
		check("load", 60, rd[22:16]);
		check("target", 16'h3e8, tspeed);
		check("rack sat", 0, track);
		check("current sat", 0, cur);
		repeat (100) begin
			@(posedge clock);
			pwm_high += pwm;
		end
		check("pwm duty", 60, pwm_high);
		cool <= 8'sh3b;
		ticks();
		check("egr cold", 0, egr);
		cool <= 8'shf6;
		ticks();
		check("egr below zero", 0, egr);
		cool <= 8'sh46;
		stop <= 1'b1;
		ticks();
		check("egr stop", 0, egr);
		stop <= 1'b0;
		bus(1, `REG_CTRL, 32'h20);
		ticks();
		check("load can", 60, lcan);
		accel <= 16'h0000;
		ticks();
		check("clamp low", 16'h320, tspeed);
		accel <= 16'hffff;
		ticks();
		check("clamp high", 16'h9c4, tspeed);
		check("iso", 0, droop);
		droop_in <= 1'b0;
		accel <= 16'h03e8;
		bus(1, `REG_CTRL, 32'h0);
		ticks();
		check("droop", 1, droop);
		check("droop target", 16'h370, tspeed);
		accel <= 16'h0320;
		bus(1, `REG_CTRL, 32'h08);
		ticks();
		check("droop floor", 16'h320, tspeed);
		bus(1, `REG_CTRL, 32'h04);
		ticks();
		check("droop invert", 0, droop);
		droop_in <= 1'b1;
		accel <= 16'h03e8;
		bus(1, `REG_CTRL, 32'h0);
		cool <= 8'sh00;
		starting <= 1'b1;
		ticks();
		check("sol on", 1, sol);
		check("advance", 16'h41a, tspeed);
		accel <= 16'hffff;
		ticks();
		check("advance cap", 16'h9c4, tspeed);
		check("rack rate", 1, track != 16'h0 && track <= 16'h60 && track[4:0] == 5'h0);
		accel <= 16'h03e8;
		cool <= 8'sh06;
		ticks();
		check("sol off", 0, sol);
		check("normal", 16'h3e8, tspeed);
		cool <= 8'sh03;
		ticks();
		check("sol rearm wait", 0, sol);
		cool <= 8'sh01;
		ticks();
		check("sol rearm", 1, sol);
		bus(1, `REG_CTRL, 32'h10);
		ticks();
		check("advance hot", 16'h433, tspeed);
		cool <= 8'sh0b;
		ticks();
		check("sol off hot", 0, sol);
		accel <= 16'h0000;
		bus(1, `REG_CTRL, 32'h13);
		ticks();
		check("idle raise", 16'h35a, tspeed);
		accel <= 16'hffff;
		ticks();
		check("smoke cut", 16'h98a, tspeed);
		{sa, sb, sc} <= 3'h7;
		accel <= 16'h03e8;
		bus(1, `REG_SEL_A, 32'h64);
		bus(1, `REG_SEL_B, 32'hffce);
		bus(1, `REG_SEL_C, 32'h0a);
		ticks();
		check("select", 16'h45e, tspeed);
		report_and_stop();
	end
endmodule : engine_speed_governor_control_bench
